// file: seprr_pkg.sv
// Package for the serial EEPROM slave with write guard and reset stretching.
// Assumes a single 40 MHz reference clock drives every consumer of these constants.
package seprr_pkg;

  // Reference clock rate in hertz.
  localparam int CLK_HZ = 40_000_000;

  // Manual reset stretch interval in milliseconds, and its cycle count.
  localparam int RESET_STRETCH_MS = 200;
  localparam int RESET_STRETCH_CYCLES = RESET_STRETCH_MS * (CLK_HZ / 1000);

  // Internal programming cycle in milliseconds, and its cycle count.
  localparam int PROG_CYCLE_MS = 5;
  localparam int PROG_CYCLES = PROG_CYCLE_MS * (CLK_HZ / 1000);

  // Width of the long timers; holds up to about 8.4 million cycles.
  localparam int TIMER_W = 23;

  // Memory geometry.
  localparam int MEM_BYTES = 2048;
  localparam int ADDR_W = 11;
  localparam int HI_ADDR_W = 3;
  localparam int PAGE_BITS = 4;

  // Write staging buffer: address plus data per entry.
  localparam int STAGE_DEPTH = 32;
  localparam int STAGE_W = ADDR_W + 8;

  // Fixed device type in the upper nibble of the slave address byte.
  localparam logic [3:0] DEV_TYPE = 4'ha;

  // Bit count at which a byte is complete.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Number of pins passed through the input synchronisers.
  localparam int SYNC_N = 5;
  localparam int SYNC_SCL = 0;
  localparam int SYNC_SDA = 1;
  localparam int SYNC_RHI = 2;
  localparam int SYNC_RLO = 3;
  localparam int SYNC_WG = 4;

  // Serial protocol states.
  typedef enum logic [2:0] {
    SEPRR_IDLE,
    SEPRR_DEV,
    SEPRR_WORD,
    SEPRR_WDATA,
    SEPRR_RDATA,
    SEPRR_RACK,
    SEPRR_WAIT
  } seprr_state_e;

endpackage

// file: seprr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on ref_clk; rst is synchronous and active high.
`timescale 1ns/1ps
module seprr_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side.
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side.
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  logic [AW:0] next_wrPtr;
  logic [AW:0] next_rdPtr;
  logic full;
  logic empty;

  // Pointers carry one extra bit so full and empty stay distinct.
  always_comb
  begin
    full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    empty = (wrPtr == rdPtr);
    inReady = !full;
    outValid = !empty;
    outData = store[rdPtr[AW-1:0]];
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    if (inValid && !full)
    begin
      next_wrPtr = wrPtr + 1'b1;
    end
    if (outReady && !empty)
    begin
      next_rdPtr = rdPtr + 1'b1;
    end
  end

  // Storage has no reset; only the pointers define what is valid.
  always_ff @(posedge ref_clk)
  begin
    if (inValid && !full)
    begin
      store[wrPtr[AW-1:0]] <= inData;
    end
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end
endmodule

// file: seprr_reset_stretch.sv
// Manual reset edge sensing and fixed-length stretching of the opposite reset pin.
// Assumes pin levels arrive already synchronised to ref_clk.
`timescale 1ns/1ps
module seprr_reset_stretch #(
  parameter int STRETCH = seprr_pkg::RESET_STRETCH_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Synchronised pin levels.
  input wire logic hiLevel,
  input wire logic loLevel_n,
  // Pin drive enables and memory lockout.
  output logic hiDrive,
  output logic loDrive,
  output logic memOff
);
  import seprr_pkg::*;

  logic [TIMER_W-1:0] cnt;
  logic [TIMER_W-1:0] next_cnt;
  logic hiPrev;
  logic loPrev;
  logic next_hiDrive;
  logic next_loDrive;
  logic hiRise;
  logic loFall;

  // Edges caused by our own drive are ignored, so the two pins cannot retrigger each other.
  always_comb
  begin
    hiRise = hiLevel && !hiPrev && !hiDrive; // [RQ13]
    loFall = !loLevel_n && loPrev && !loDrive; // [RQ13]
    next_cnt = cnt;
    next_hiDrive = hiDrive;
    next_loDrive = loDrive;
    if (hiRise || loFall)
    begin
      next_cnt = TIMER_W'(STRETCH - 1); // [RQ14]
      next_loDrive = loDrive || hiRise; // [RQ14]
      next_hiDrive = hiDrive || loFall; // [RQ14]
    end
    else if (cnt != '0)
    begin
      next_cnt = cnt - 1'b1;
    end
    else
    begin
      // Expiry releases the output even if the input is still forced.
      next_hiDrive = 1'b0; // [RQ15]
      next_loDrive = 1'b0; // [RQ15]
    end
  end

  // Power-up behaves like a stretch with both pins driven.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt <= TIMER_W'(STRETCH - 1);
      hiDrive <= 1'b1;
      loDrive <= 1'b1;
      hiPrev <= 1'b0;
      loPrev <= 1'b1;
      memOff <= 1'b1;
    end
    else
    begin
      cnt <= next_cnt;
      hiDrive <= next_hiDrive;
      loDrive <= next_loDrive;
      hiPrev <= hiLevel;
      loPrev <= loLevel_n;
      memOff <= next_hiDrive || next_loDrive || hiLevel || !loLevel_n; // [RQ16] [RQ17]
    end
  end
endmodule

// file: seprr_eeprom.sv
// Top of the two-wire serial EEPROM slave: protocol engine, 2048-byte array,
// write staging buffer and manual reset handling.
// Assumes every pin input is asynchronous to ref_clk and is resolved by the bench.
//
// Notes on behaviour
// [RQ1] During the programming cycle, a write-direction slave address gets no acknowledge.
// [RQ2] After programming ends, a write-direction slave address is acknowledged again.
// [RQ3] Host polls completion by repeated START plus write-direction slave address.
// [RQ4] With write guard high, the array is read only, nothing is programmed.
// [RQ5] Under write guard, addresses are acknowledged, first data byte is not.
// [RQ6] A read starts like a write but with the direction bit one.
// [RQ7] Address counter holds last accessed location plus one for current reads.
// [RQ8] After location 2047 the counter rolls over to location 0.
// [RQ9] Current read: acknowledge address, send one byte, host nacks then stops.
// [RQ10] Random read: dummy write of address, then repeated START with read direction.
// [RQ11] In sequential read, each host acknowledge brings another byte.
// [RQ12] Sequential reads increment all address bits, wrapping after 2047.
// [RQ13] Manual reset inputs are edge sensed: rise on high pin, fall on low.
// [RQ14] A sensed edge drives the complementary reset output for 200 ms.
// [RQ15] The complementary output returns inactive at 200 ms even if input stays.
// [RQ16] Memory answers nothing while either reset pin is in reset; a read already under way keeps driving its data bytes.
// [RQ17] A forced reset beyond the timeout keeps all accesses unacknowledged.
// [RQ18] Slave address: type nibble, three high address bits, direction bit.
// [RQ19] After the write slave address the host sends the low address byte.
// [RQ20] Page write wraps in the low four address bits, overwriting earlier data.
// [RQ21] A host nack after a read byte ends transmission until STOP.
// [RQ22] A timer sets the programming cycle; addressing is ignored meanwhile.
`timescale 1ns/1ps
module seprr_eeprom #(
  parameter int STRETCH = seprr_pkg::RESET_STRETCH_CYCLES,
  parameter int PROG = seprr_pkg::PROG_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Serial clock and open-drain data.
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Active-high reset pin, open drain style.
  input wire logic rstHiIn,
  output logic rstHiOut,
  output logic rstHiOe,
  // Active-low reset pin, open drain style.
  input wire logic rstLoIn_n,
  output logic rstLoOut_n,
  output logic rstLoOe,
  // Write guard and status.
  input wire logic writeGuard,
  output logic writeBusy
);
  import seprr_pkg::*;

  logic [SYNC_N-1:0] syncA;
  logic [SYNC_N-1:0] syncB;
  logic sclD;
  logic sdaD;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;

  seprr_state_e state;
  seprr_state_e next_state;
  logic [3:0] bitCnt;
  logic [3:0] next_bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic ackPhase;
  logic next_ackPhase;
  logic next_sdaOe;
  logic [ADDR_W-1:0] addrPtr;
  logic [ADDR_W-1:0] next_addrPtr;
  logic [HI_ADDR_W-1:0] addrHi;
  logic [HI_ADDR_W-1:0] next_addrHi;
  logic dirty;
  logic next_dirty;
  logic next_writeBusy;
  logic [TIMER_W-1:0] progCnt;
  logic [TIMER_W-1:0] next_progCnt;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rdByte;
  logic pushValid;
  logic [STAGE_W-1:0] pushData;
  logic stageReady;
  logic stageValid;
  logic [STAGE_W-1:0] stageData;
  logic hiDrive;
  logic loDrive;
  logic memOff;

  // Two flip-flops per pin input; the second stage is looked at, and SCL and SDA add a third for edges.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      syncA <= 5'h1f;
      syncB <= 5'h1f;
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end
    else
    begin
      syncA <= {writeGuard, rstLoIn_n, rstHiIn, sdaIn, scl};
      syncB <= syncA;
      sclD <= syncB[SYNC_SCL];
      sdaD <= syncB[SYNC_SDA];
    end
  end

  // Edge and bus condition detection on the synchronised lines.
  always_comb
  begin
    sclS = syncB[SYNC_SCL];
    sdaS = syncB[SYNC_SDA];
    sclRise = sclS && !sclD;
    sclFall = !sclS && sclD;
    startC = sclS && sclD && sdaD && !sdaS;
    stopC = sclS && sclD && !sdaD && sdaS;
    rdByte = mem[addrPtr];
  end

  // Protocol engine, programming timer and address counter.
  always_comb
  begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_ackPhase = ackPhase;
    next_sdaOe = sdaOe;
    next_addrPtr = addrPtr;
    next_addrHi = addrHi;
    next_dirty = dirty;
    next_writeBusy = writeBusy;
    next_progCnt = progCnt;
    pushValid = 1'b0;
    pushData = {addrPtr, shiftReg};
    // Programming lasts for the timer and until every staged byte is stored.
    if (writeBusy)
    begin
      if (progCnt != '0)
      begin
        next_progCnt = progCnt - 1'b1;
      end
      else if (!stageValid)
      begin
        next_writeBusy = 1'b0; // [RQ2] [RQ22]
      end
    end
    if (startC || stopC)
    begin
      // Staged data is committed at STOP, or at a repeated START that ends the write.
      if (dirty)
      begin
        next_writeBusy = 1'b1; // [RQ22]
        next_progCnt = TIMER_W'(PROG - 1); // [RQ22]
        next_dirty = 1'b0;
      end
      next_sdaOe = 1'b0;
      next_ackPhase = 1'b0;
      next_bitCnt = '0;
      next_state = startC ? SEPRR_DEV : SEPRR_IDLE;
    end
    else
    begin
      case (state)
        SEPRR_DEV, SEPRR_WORD, SEPRR_WDATA:
        begin
          if (sclRise && !ackPhase && bitCnt != BYTE_BITS)
          begin
            next_shiftReg = {shiftReg[6:0], sdaS};
            next_bitCnt = bitCnt + 1'b1;
          end
          else if (sclFall && !ackPhase && bitCnt == BYTE_BITS)
          begin
            next_ackPhase = 1'b1;
            if (state == SEPRR_DEV)
            begin
              // Type must match; busy or reset lockout withholds the acknowledge.
              next_sdaOe = (shiftReg[7:4] == DEV_TYPE) && !writeBusy && !memOff; // [RQ1] [RQ2] [RQ16] [RQ17] [RQ18]
            end
            else if (state == SEPRR_WORD)
            begin
              next_sdaOe = !memOff; // [RQ5] [RQ19]
            end
            else
            begin
              // A full staging buffer also refuses the byte, pushing back on the host.
              next_sdaOe = !syncB[SYNC_WG] && stageReady && !memOff; // [RQ4] [RQ5]
              pushValid = !syncB[SYNC_WG] && stageReady && !memOff; // [RQ4]
              next_addrPtr = {addrPtr[ADDR_W-1:PAGE_BITS], addrPtr[PAGE_BITS-1:0] + 4'h1}; // [RQ20]
              next_dirty = dirty || pushValid;
              if (!pushValid)
              begin
                next_addrPtr = addrPtr; // [RQ5]
              end
            end
          end
          else if (sclFall && ackPhase)
          begin
            next_ackPhase = 1'b0;
            next_bitCnt = '0;
            next_sdaOe = 1'b0;
            if (!sdaOe)
            begin
              next_state = SEPRR_WAIT;
            end
            else if (state == SEPRR_DEV && shiftReg[0])
            begin
              // Read direction: send the byte at the counter, then advance it.
              next_state = SEPRR_RDATA; // [RQ6] [RQ9]
              next_shiftReg = rdByte; // [RQ7]
              next_sdaOe = !rdByte[7];
              next_addrPtr = addrPtr + 1'b1; // [RQ7] [RQ8]
            end
            else if (state == SEPRR_DEV)
            begin
              next_addrHi = shiftReg[3:1]; // [RQ18]
              next_state = SEPRR_WORD;
            end
            else if (state == SEPRR_WORD)
            begin
              // A following repeated START turns this into the random read setup.
              next_addrPtr = {addrHi, shiftReg}; // [RQ10] [RQ19]
              next_state = SEPRR_WDATA;
            end
          end
        end
        SEPRR_RDATA:
        begin
          if (sclRise)
          begin
            next_bitCnt = bitCnt + 1'b1;
          end
          else if (sclFall && bitCnt == BYTE_BITS)
          begin
            next_sdaOe = 1'b0;
            next_bitCnt = '0;
            next_state = SEPRR_RACK;
          end
          else if (sclFall)
          begin
            next_shiftReg = {shiftReg[6:0], 1'b0};
            next_sdaOe = !shiftReg[6];
          end
        end
        SEPRR_RACK:
        begin
          if (sclRise && !ackPhase)
          begin
            if (!sdaS)
            begin
              next_ackPhase = 1'b1; // [RQ11]
            end
            else
            begin
              next_state = SEPRR_WAIT; // [RQ9] [RQ21]
            end
          end
          else if (sclFall && ackPhase)
          begin
            // Every host acknowledge fetches the next location across the whole array.
            next_ackPhase = 1'b0;
            next_shiftReg = rdByte; // [RQ11]
            next_sdaOe = !rdByte[7];
            next_addrPtr = addrPtr + 1'b1; // [RQ12] [RQ8]
            next_state = SEPRR_RDATA;
          end
        end
        SEPRR_IDLE, SEPRR_WAIT:
        begin
          next_sdaOe = 1'b0;
        end
        default:
        begin
          next_state = SEPRR_IDLE;
          next_sdaOe = 1'b0;
        end
      endcase
    end
  end

  // Protocol registers and pin drive; reset pins drive only their active level.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= SEPRR_IDLE;
      bitCnt <= '0;
      shiftReg <= '0;
      ackPhase <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      addrPtr <= '0;
      addrHi <= '0;
      dirty <= 1'b0;
      writeBusy <= 1'b0;
      progCnt <= '0;
      rstHiOut <= 1'b1;
      rstLoOut_n <= 1'b0;
      rstHiOe <= 1'b1;
      rstLoOe <= 1'b1;
    end
    else
    begin
      state <= next_state;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      ackPhase <= next_ackPhase;
      sdaOe <= next_sdaOe;
      sdaOut <= 1'b0;
      addrPtr <= next_addrPtr;
      addrHi <= next_addrHi;
      dirty <= next_dirty;
      writeBusy <= next_writeBusy;
      progCnt <= next_progCnt;
      rstHiOut <= 1'b1;
      rstLoOut_n <= 1'b0;
      rstHiOe <= hiDrive; // [RQ14]
      rstLoOe <= loDrive; // [RQ14]
    end
  end

  // The array is written only while programming, one staged byte per cycle.
  always_ff @(posedge ref_clk)
  begin
    if (writeBusy && stageValid)
    begin
      mem[stageData[STAGE_W-1:8]] <= stageData[7:0]; // [RQ20] [RQ4]
    end
  end

  // Received bytes wait here until the programming cycle drains them in order.
  seprr_fifo #(
    .WIDTH(STAGE_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(pushValid),
    .inData(pushData),
    .inReady(stageReady),
    .outValid(stageValid),
    .outData(stageData),
    .outReady(writeBusy)
  );

  // Manual reset sensing and lockout of the memory.
  seprr_reset_stretch #(
    .STRETCH(STRETCH)
  ) u_stretch (
    .ref_clk(ref_clk),
    .rst(rst),
    .hiLevel(syncB[SYNC_RHI]),
    .loLevel_n(syncB[SYNC_RLO]),
    .hiDrive(hiDrive),
    .loDrive(loDrive),
    .memOff(memOff)
  );
endmodule

// file: seprr_eeprom_monitor.sv
// Pin-level checks for the serial EEPROM slave top.
// Assumes it is bound to seprr_eeprom and sees its ports only.
`timescale 1ns/1ps
module seprr_eeprom_monitor #(
  parameter int STRETCH = seprr_pkg::RESET_STRETCH_CYCLES,
  parameter int PROG = seprr_pkg::PROG_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Serial pins.
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Reset pins.
  input wire logic rstHiIn,
  input wire logic rstHiOut,
  input wire logic rstHiOe,
  input wire logic rstLoIn_n,
  input wire logic rstLoOut_n,
  input wire logic rstLoOe,
  // Guard and status.
  input wire logic writeGuard,
  input wire logic writeBusy
);
  logic [23:0] busyCnt;
  logic [23:0] hiCnt;
  logic [23:0] loCnt;
  logic [23:0] next_busyCnt;
  logic [23:0] next_hiCnt;
  logic [23:0] next_loCnt;

  // Run lengths of the busy flag and both drives; they restart whenever the level drops.
  always_comb
  begin
    next_busyCnt = writeBusy ? busyCnt + 24'h00_0001 : 24'h00_0000;
    next_hiCnt = rstHiOe ? hiCnt + 24'h00_0001 : 24'h00_0000;
    next_loCnt = rstLoOe ? loCnt + 24'h00_0001 : 24'h00_0000;
  end

  // Drive runs start one below zero in reset: the power-up drive is sampled once more
  // after release than a manual stretch, so both then end on the same count.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busyCnt <= 24'h00_0000;
      hiCnt <= 24'hff_ffff;
      loCnt <= 24'hff_ffff;
    end
    else
    begin
      busyCnt <= next_busyCnt;
      hiCnt <= next_hiCnt;
      loCnt <= next_loCnt;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // A pin held in its reset level long enough to pass the synchronisers.
  sequence lockHeld;
    (rstHiIn || !rstLoIn_n) [*6];
  endsequence

  // Programming has been running for more than one cycle.
  sequence busyOn;
    writeBusy && $past(writeBusy);
  endsequence

  busy_len_a: assert property ($fell(writeBusy) |-> busyCnt == PROG)
    else $error("programming cycle length wrong");
  busy_quiet_a: assert property (busyOn |-> !sdaOe)
    else $error("bus answered during programming");
  busy_start_a: assert property ($rose(writeBusy) |-> $past(scl, 3))
    else $error("programming began outside a stop");
  lo_len_a: assert property ($fell(rstLoOe) |-> loCnt == STRETCH)
    else $error("low reset drive length wrong");
  hi_len_a: assert property ($fell(rstHiOe) |-> hiCnt == STRETCH)
    else $error("high reset drive length wrong");
  lo_edge_a: assert property ($rose(rstLoOe) |-> $past(rstHiIn) && !$past(rstHiIn, 6))
    else $error("low drive without a rising edge");
  hi_edge_a: assert property ($rose(rstHiOe) |-> !$past(rstLoIn_n) && $past(rstLoIn_n, 6))
    else $error("high drive without a falling edge");
  lock_quiet_a: assert property (lockHeld |-> !sdaOe)
    else $error("bus answered while reset held");
  sda_timing_a: assert property ($changed(sdaOe) |-> !$past(scl, 2))
    else $error("data line moved while clock high");
endmodule

bind seprr_eeprom seprr_eeprom_monitor #(.STRETCH(STRETCH), .PROG(PROG)) uMon (
  .ref_clk, .rst, .scl, .sdaIn, .sdaOut, .sdaOe, .rstHiIn, .rstHiOut, .rstHiOe,
  .rstLoIn_n, .rstLoOut_n, .rstLoOe, .writeGuard, .writeBusy
);

// file: seprr_i2c_host.sv
// Behavioural two-wire bus host that clocks the EEPROM slave.
// Assumes the bench resolves the open-drain data wire; SCL idles high between frames.
`timescale 1ns/1ps
module seprr_i2c_host (
  // Clock.
  input wire logic ref_clk,
  // Resolved data wire.
  input wire logic sdaWire,
  // Host drives; sdaPull high pulls the data wire low.
  output logic scl,
  output logic sdaPull
);
  // Bus idle at time zero.
  initial
  begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // Waits n clock edges, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Start or repeated start; also used for polling after a write.
  task automatic start();
    tick(2);
    sdaPull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sdaPull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  // Stop; the clock then stands high.
  task automatic stop();
    tick(2);
    sdaPull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sdaPull = 1'b0;
    tick(4);
  endtask

  // One 200 ns bit: data set mid-low so it never moves while the clock is high.
  task automatic bitSlot(input logic b, output logic s);
    tick(2);
    sdaPull = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    s = sdaWire;
    scl = 1'b0;
  endtask

  // Sends a byte MSB first and returns whether the slave pulled the ninth bit low.
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitSlot(b[i], s);
    bitSlot(1'b1, s);
    ack = (s === 1'b0);
  endtask

  // Reads a byte, then acknowledges it or not.
  task automatic rdByte(input logic ackIt, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitSlot(1'b1, s);
      b[i] = s;
    end
    bitSlot(~ackIt, s);
  endtask
endmodule

// file: tb.sv
// Self-checking bench for the serial EEPROM slave top.
// Assumes the host model and the bound monitor compile alongside.
`timescale 1ns/1ps
module tb;
  import seprr_pkg::*;
  localparam int STRETCH = 200;
  localparam int PROG = 200;
  localparam int LIMIT = 40000;
  logic ref_clk;
  logic rst;
  logic extHi;
  logic extLo;
  logic writeGuard;
  logic hostScl;
  logic hostPull;
  logic sdaOut, sdaOe, rstHiOut, rstHiOe, rstLoOut_n, rstLoOe, writeBusy;
  logic [7:0] mem [0:2047];
  int badCount = 0;
  int nCompared = 0;
  int cycles = 0;
  // Wired-AND data, pulled-down high reset, pulled-up low reset.
  // The driven pin values are honoured, so a wrong drive level shows on the wires.
  wire sdaWire = ~hostPull & (sdaOe ? sdaOut : 1'b1);
  wire rstHiWire = (rstHiOe & rstHiOut) | extHi;
  wire rstLoWire_n = (rstLoOe ? rstLoOut_n : 1'b1) & ~extLo;

  always #12.5 ref_clk = ~ref_clk;

  seprr_i2c_host hst (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(hostScl), .sdaPull(hostPull));

  seprr_eeprom #(.STRETCH(STRETCH), .PROG(PROG)) DUT (
    .ref_clk(ref_clk), .rst(rst), .scl(hostScl), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .rstHiIn(rstHiWire), .rstHiOut(rstHiOut), .rstHiOe(rstHiOe),
    .rstLoIn_n(rstLoWire_n), .rstLoOut_n(rstLoOut_n), .rstLoOe(rstLoOe),
    .writeGuard(writeGuard), .writeBusy(writeBusy)
  );

  task automatic giveVerdict();
    $display("Compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      badCount++;
      giveVerdict();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    nCompared++;
    if (seen !== exp)
    begin
      badCount++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [7:0] devByte(input logic [2:0] hi, input logic rd);
    return {DEV_TYPE, hi, rd};
  endfunction

  // Write frame up to the word address; this is also the dummy write of a random read.
  task automatic openAt(input logic [10:0] a);
    logic k;
    hst.start();
    hst.wrByte(devByte(a[10:8], 1'b0), k);
    chk(k, 1'b1, "slave address ack");
    hst.wrByte(a[7:0], k);
    chk(k, 1'b1, "word address ack");
  endtask

  // Single address probe, judged against the expected acknowledge.
  task automatic probe(input logic expAck);
    logic k;
    hst.start();
    hst.wrByte(devByte(3'h0, 1'b0), k);
    hst.stop();
    chk(k, expAck, "probe ack");
  endtask

  // Polls from the stop on; the first try must be refused while programming runs.
  task automatic pollDone();
    logic k;
    int tries;
    tries = 0;
    k = 1'b0;
    while (!k && tries < 20)
    begin
      hst.start();
      hst.wrByte(devByte(3'h0, 1'b0), k);
      tries++;
    end
    hst.stop();
    chk(tries > 1, 1'b1, "poll refused while busy");
    chk(k, 1'b1, "poll accepted after cycle");
  endtask

  // Page write; bytes past the page end wrap and overwrite, as the model mirrors.
  task automatic writeRun(input logic [10:0] a, input int n, input logic [7:0] seed);
    logic k;
    logic [7:0] d;
    openAt(a);
    for (int i = 0; i < n; i++)
    begin
      d = seed + 8'(i);
      hst.wrByte(d, k);
      chk(k, 1'b1, "data ack");
      mem[{a[10:4], a[3:0] + 4'(i)}] = d;
    end
    hst.stop();
    hst.tick(8);
    chk(writeBusy, 1'b1, "programming started");
    pollDone();
  endtask

  // Random read from a, or current read expecting a, of n bytes; one more after the nack.
  task automatic readRun(input logic [10:0] a, input int n, input logic cur);
    logic k;
    logic [7:0] d;
    logic [10:0] p;
    p = a;
    if (!cur)
      openAt(a);
    hst.start();
    hst.wrByte(devByte(3'h0, 1'b1), k);
    chk(k, 1'b1, "read address ack");
    for (int i = 0; i < n; i++)
    begin
      hst.rdByte(i < n - 1, d);
      chk(d, mem[p], "read data");
      p = p + 11'h001;
    end
    hst.rdByte(1'b0, d);
    chk(d, 8'hff, "released after host nack");
    hst.stop();
  endtask

  task automatic scnWrites();
    writeRun(11'h000, 1, 8'ha5);
    writeRun(11'h7fe, 18, 8'h10);
  endtask

  task automatic scnReads();
    readRun(11'h7f0, 16, 1'b0);
    readRun(11'h000, 1, 1'b1);
    readRun(11'h7ff, 2, 1'b0);
  endtask

  // Guarded write: addresses taken, data refused, nothing programmed; wrong type refused.
  task automatic scnGuard();
    logic k;
    writeGuard = 1'b1;
    openAt(11'h000);
    hst.wrByte(8'h3c, k);
    chk(k, 1'b0, "guarded data nack");
    hst.stop();
    hst.tick(8);
    chk(writeBusy, 1'b0, "no programming under guard");
    hst.start();
    hst.wrByte({4'hb, 4'h0}, k);
    hst.stop();
    chk(k, 1'b0, "foreign type nack");
    writeGuard = 1'b0;
    readRun(11'h000, 1, 1'b0);
  endtask

  // Manual reset pulses on both pins, one short and one held past the stretch.
  task automatic scnResetPins();
    int t0;
    t0 = cycles;
    extHi = 1'b1;
    hst.tick(10);
    extHi = 1'b0;
    hst.tick(4);
    chk(rstLoOe, 1'b1, "low drive started");
    probe(1'b0);
    hst.tick(STRETCH - 20 - (cycles - t0));
    chk(rstLoOe, 1'b1, "low drive still on");
    hst.tick(40);
    chk(rstLoOe, 1'b0, "low drive ended");
    probe(1'b1);
    t0 = cycles;
    extLo = 1'b1;
    hst.tick(10);
    chk(rstHiOe, 1'b1, "high drive started");
    hst.tick(STRETCH + 20 - (cycles - t0));
    chk(rstHiOe, 1'b0, "high drive ends while held");
    probe(1'b0);
    chk(rstHiOe, 1'b0, "held level gives no new drive");
    extLo = 1'b0;
    hst.tick(10);
    probe(1'b1);
    chk({sdaOut, rstHiOut, rstLoOut_n}, 3'b010, "pin drive levels");
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    extHi = 1'b0;
    extLo = 1'b0;
    writeGuard = 1'b0;
    hst.tick(16);
    rst = 1'b0;
    hst.tick(STRETCH + 40);
    scnWrites();
    scnReads();
    scnGuard();
    scnResetPins();
    giveVerdict();
  end
endmodule
